// [logic/lpr_pkg.sv]
// package: register map, fields, resets and carriers of the pulse RAM and rx config slice
package lpr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LPR_OFF_RAM_ADDR = 8'h08;
  localparam logic [7:0] LPR_OFF_RAM_DATA = 8'h09;
  localparam logic [7:0] LPR_OFF_RX_CFG0 = 8'h0A;
  localparam logic [7:0] LPR_OFF_RX_CFG1 = 8'h0B;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LPR_BIT_TRIGGER = 7;
  localparam int LPR_BIT_DIRECTION = 6;
  localparam int LPR_POS_INTERVAL = 4;
  localparam int LPR_POS_SAMPLE = 0;
  localparam int LPR_POS_AMPLITUDE = 0;
  localparam int LPR_BIT_POWER_DOWN = 4;
  localparam int LPR_BIT_POLARITY = 3;
  localparam int LPR_BIT_CLOCK_EDGE = 2;
  localparam int LPR_POS_DECODE = 0;
  localparam int LPR_BIT_EQUALIZER = 6;
  localparam int LPR_POS_LOSS = 0;

  // ----------------------------------------------------------------
  // reset values and geometry
  // ----------------------------------------------------------------
  localparam logic [4:0] LPR_RST_LOSS = 5'h15;
  localparam logic [4:0] LPR_LOSS_SATURATE = 5'h16;
  localparam logic [6:0] LPR_RST_AMPLITUDE = 7'h00;
  localparam int LPR_INTERVALS = 4;
  localparam int LPR_SAMPLES = 16;
  localparam int LPR_AMP_WIDTH = 7;

  typedef enum logic [1:0] {
    LPR_DEC_HDB3_B8ZS,
    LPR_DEC_AMI,
    LPR_DEC_DUAL_RAIL,
    LPR_DEC_SLICER
  } lpr_decode_t;

  typedef struct packed {
    logic [1:0] intervalSelect;
    logic [3:0] sampleSelect;
  } lpr_ram_addr_t;

  // receive-path controls handed to the analog and decode logic
  typedef struct packed {
    logic powerDown;
    logic rxPolarity;
    logic fallingEdge;
    lpr_decode_t rxDecodeMode;
    logic clockDataRecovery;
    logic decoderBypass;
    logic singleRail;
    logic equalizerEnable;
    logic [4:0] signalLossThreshold;
    logic [4:0] lossClearStep;
  } lpr_rx_ctrl_t;

endpackage

// [logic/lpr_template_ram.sv]
// file: pulse template storage, flip-flops addressed by interval and sample
`timescale 1ns/1ps
module lpr_template_ram #(
  parameter int INTERVALS = lpr_pkg::LPR_INTERVALS,
  parameter int SAMPLES = lpr_pkg::LPR_SAMPLES,
  parameter int WIDTH = lpr_pkg::LPR_AMP_WIDTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic writeEnable,
  input wire logic [$clog2(INTERVALS*SAMPLES)-1:0] index,
  input wire logic [WIDTH-1:0] writeData,
  output logic [WIDTH-1:0] readData
);

  initial begin
    if (INTERVALS < 2 || SAMPLES < 2 || WIDTH < 1) begin
      $error("lpr_template_ram: unsupported geometry");
    end
  end

  logic [WIDTH-1:0] store [INTERVALS*SAMPLES];

  // combinational read; the caller registers it
  assign readData = store[index];

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < INTERVALS*SAMPLES; i++) begin
        store[i] <= '0;
      end
    end else if (writeEnable) begin
      store[index] <= writeData;
    end
  end

endmodule // lpr_template_ram

// [logic/lpr_control_regs.sv]
// file: top of the pulse RAM access and receive configuration register slice
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module lpr_control_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  output lpr_pkg::lpr_rx_ctrl_t rxCtrl
);

  // ----------------------------------------------------------------
  // stored fields
  // ----------------------------------------------------------------
  logic readDirection;
  lpr_pkg::lpr_ram_addr_t ramAddr;
  logic [6:0] sampleAmplitude;
  logic powerDown;
  logic rxPolarity;
  logic fallingEdge;
  logic [1:0] rxDecodeMode;
  logic equalizerEnable;
  logic [4:0] signalLossThreshold;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic hitAddr = regAddr == lpr_pkg::LPR_OFF_RAM_ADDR;
  wire logic hitData = regAddr == lpr_pkg::LPR_OFF_RAM_DATA;
  wire logic hitCfg0 = regAddr == lpr_pkg::LPR_OFF_RX_CFG0;
  wire logic hitCfg1 = regAddr == lpr_pkg::LPR_OFF_RX_CFG1;
  wire logic wrAddr = regWrite && hitAddr;

  // trigger access: trigger only acts when written as one
  wire logic trigger = wrAddr && regWriteData[lpr_pkg::LPR_BIT_TRIGGER];
  // access direction: the direction written alongside the trigger counts
  wire logic accessDir = regWriteData[lpr_pkg::LPR_BIT_DIRECTION];
  wire logic ramWrite = trigger && !accessDir;
  // interval address and sample address form the index
  wire logic [1:0] nextInterval = wrAddr ?
    regWriteData[lpr_pkg::LPR_POS_INTERVAL +: 2] : ramAddr.intervalSelect;
  wire logic [3:0] nextSample = wrAddr ?
    regWriteData[lpr_pkg::LPR_POS_SAMPLE +: 4] : ramAddr.sampleSelect;
  wire logic [5:0] ramIndex = {nextInterval, nextSample};
  wire logic [6:0] ramReadData;

  lpr_template_ram u_ram (
    .clk(clk),
    .reset(reset),
    .writeEnable(ramWrite),
    .index(ramIndex),
    .writeData(sampleAmplitude),
    .readData(ramReadData)
  );

  // reserved zero: unused bits are never stored and read as zero
  wire logic [7:0] readMux =
    hitAddr ? {1'b0, readDirection, ramAddr.intervalSelect,
               ramAddr.sampleSelect} :
    hitData ? {1'b0, sampleAmplitude} :
    hitCfg0 ? {3'b000, powerDown, rxPolarity, fallingEdge, rxDecodeMode} :
    hitCfg1 ? {1'b0, equalizerEnable, 1'b0, signalLossThreshold} :
    8'h00;

  // loss levels: steps of 2 dB saturate at code 10110
  wire logic [4:0] lossStep =
    (signalLossThreshold >= lpr_pkg::LPR_LOSS_SATURATE) ?
    lpr_pkg::LPR_LOSS_SATURATE : signalLossThreshold;

  // decoding modes, dual rail, slicer bypass
  wire logic slicerMode = rxDecodeMode == 2'h3;
  wire logic dualRail = rxDecodeMode[1];

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      readDirection <= 1'b0;
      ramAddr <= '0;
      powerDown <= 1'b0;
      rxPolarity <= 1'b0;
      fallingEdge <= 1'b0;
      rxDecodeMode <= 2'h0;
      equalizerEnable <= 1'b0;
      signalLossThreshold <= lpr_pkg::LPR_RST_LOSS;
    end else if (regWrite) begin
      if (hitAddr) begin
        readDirection <= regWriteData[lpr_pkg::LPR_BIT_DIRECTION];
        ramAddr <= {nextInterval, nextSample};
      end
      if (hitCfg0) begin
        powerDown <= regWriteData[lpr_pkg::LPR_BIT_POWER_DOWN];
        rxPolarity <= regWriteData[lpr_pkg::LPR_BIT_POLARITY];
        fallingEdge <= regWriteData[lpr_pkg::LPR_BIT_CLOCK_EDGE];
        rxDecodeMode <= regWriteData[lpr_pkg::LPR_POS_DECODE +: 2];
      end
      if (hitCfg1) begin
        equalizerEnable <= regWriteData[lpr_pkg::LPR_BIT_EQUALIZER];
        signalLossThreshold <= regWriteData[lpr_pkg::LPR_POS_LOSS +: 5];
      end
    end
  end

  // read result: the RAM answer replaces the amplitude at the same edge that takes the trigger write
  always_ff @(posedge clk) begin
    if (reset) begin
      sampleAmplitude <= lpr_pkg::LPR_RST_AMPLITUDE;
    end else begin
      if (trigger && accessDir) begin
        sampleAmplitude <= ramReadData;
      end else if (regWrite && hitData) begin
        sampleAmplitude <= regWriteData[6:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      regReadData <= 8'h00;
    end else begin
      regReadData <= regRead ? readMux : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rxCtrl <= '0;
      rxCtrl.clockDataRecovery <= 1'b1;
      rxCtrl.singleRail <= 1'b1;
      rxCtrl.signalLossThreshold <= lpr_pkg::LPR_RST_LOSS;
      rxCtrl.lossClearStep <= lpr_pkg::LPR_RST_LOSS;
    end else begin
      rxCtrl.powerDown <= powerDown;
      rxCtrl.rxPolarity <= rxPolarity;
      // edge ignored: slicer output has no retiming edge
      rxCtrl.fallingEdge <= fallingEdge && !slicerMode;
      rxCtrl.rxDecodeMode <= lpr_pkg::lpr_decode_t'(rxDecodeMode);
      rxCtrl.clockDataRecovery <= !slicerMode;
      rxCtrl.decoderBypass <= dualRail;
      rxCtrl.singleRail <= !dualRail;
      rxCtrl.equalizerEnable <= equalizerEnable;
      rxCtrl.signalLossThreshold <= signalLossThreshold;
      rxCtrl.lossClearStep <= lossStep;
    end
  end

endmodule // lpr_control_regs

// [tb/lpr_control_regs_sva.sv]
// checker: bus read and receive-control relations of the register slice
`timescale 1ns/1ps
module lpr_control_regs_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire lpr_pkg::lpr_rx_ctrl_t rxCtrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire cfgWr = regWrite && regAddr == 8'h0A;
  wire lossWr = regWrite && regAddr == 8'h0B;

  a_idle_read_zero: assert property (
    !regRead |=> regReadData == 8'h00) else $error("idle read data not zero");
  a_unmapped_read_zero: assert property (
    regRead && (regAddr < 8'h08 || regAddr > 8'h0B) |=> regReadData == 8'h00)
    else $error("unmapped read not zero");
  a_trigger_reads_zero: assert property (
    regRead && regAddr == 8'h08 |=> !regReadData[7])
    else $error("trigger bit read as one");
  a_cfg_read_back: assert property (
    cfgWr ##1 (regRead && regAddr == 8'h0A)
    |=> regReadData == {3'h0, $past(regWriteData[4:0], 2)})
    else $error("config zero read back wrong");
  a_power_pol_follow: assert property (
    cfgWr |-> ##2 rxCtrl.rxPolarity == $past(regWriteData[3], 2)
    && rxCtrl.powerDown == $past(regWriteData[4], 2))
    else $error("power or polarity not applied");
  a_slicer_mode: assert property (
    cfgWr && regWriteData[1:0] == 2'b11 |-> ##2 !rxCtrl.clockDataRecovery
    && !rxCtrl.fallingEdge && !rxCtrl.singleRail)
    else $error("slicer mode controls wrong");
  a_rail_select: assert property (
    (rxCtrl.rxDecodeMode >= lpr_pkg::LPR_DEC_DUAL_RAIL) == rxCtrl.decoderBypass
    && rxCtrl.singleRail != rxCtrl.decoderBypass)
    else $error("rail selection wrong");
  a_loss_clamp: assert property (
    rxCtrl.lossClearStep == (rxCtrl.signalLossThreshold > 5'h16 ? 5'h16
    : rxCtrl.signalLossThreshold)) else $error("loss step not clamped");
  a_eq_loss_follow: assert property (
    lossWr |-> ##2 rxCtrl.equalizerEnable == $past(regWriteData[6], 2)
    && rxCtrl.signalLossThreshold == $past(regWriteData[4:0], 2))
    else $error("equalizer or loss code not applied");
endmodule // lpr_control_regs_sva

// [tb/tb.sv]
// testbench: register slice driven over its plain register port
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWriteData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regReadData;
  lpr_pkg::lpr_rx_ctrl_t rxCtrl;
  int bad_count = 0;
  int num_checks = 0;
  always #20 clk = ~clk;
  lpr_control_regs DUT (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .rxCtrl(rxCtrl));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobe stays up so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRead <= 1'b1;
    regWrite <= 1'b0;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regReadData, exp);
    @(posedge clk);
  endtask
  task automatic t_ram();
    logic [5:0] ad [4] = '{6'h00, 6'h3F, 6'h15, 6'h2A};
    logic [6:0] am [4] = '{7'h0D, 7'h7F, 7'h40, 7'h2A};
    for (int i = 0; i < 4; i++) begin
      wr(8'h09, {1'b1, am[i]});
      wr(8'h08, {2'b10, ad[i]});
    end
    wr(8'h09, 8'h55);
    wr(8'h08, {2'b00, ad[0]});
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, {2'b11, ad[i]});
      rd(8'h09, {1'b0, am[i]});
    end
    rd(8'h08, {2'b01, ad[3]});
    $display("template ram test done");
  endtask
  task automatic t_rx();
    logic [1:0] mm;
    logic [7:0] d;
    for (int m = 0; m < 4; m++) begin
      mm = m[1:0];
      d = {3'b111, mm[0], ~mm[0], 1'b1, mm};
      wr(8'h0A, d);
      rd(8'h0A, {3'b000, d[4:0]});
      chk({rxCtrl.powerDown, rxCtrl.rxPolarity, rxCtrl.fallingEdge,
        rxCtrl.clockDataRecovery, rxCtrl.singleRail, rxCtrl.decoderBypass,
        2'(rxCtrl.rxDecodeMode)}, {d[4], d[3], mm != 2'b11, mm != 2'b11,
        ~mm[1], mm[1], mm});
    end
    $display("receive config test done");
  endtask
  task automatic t_loss();
    logic [4:0] cd [4] = '{5'h00, 5'h15, 5'h16, 5'h1F};
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {1'b1, i[0], 1'b1, cd[i]};
      wr(8'h0B, d);
      rd(8'h0B, {1'b0, d[6], 1'b0, d[4:0]});
      chk({2'h0, rxCtrl.equalizerEnable, rxCtrl.lossClearStep}, {2'h0, d[6],
        cd[i] > 5'h16 ? 5'h16 : cd[i]});
    end
    wr(8'h0C, 8'hFF);
    wr(8'h07, 8'hFF);
    rd(8'h0C, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h0B, 8'h5F);
    $display("loss and unmapped test done");
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(8'h0B, 8'h15);
    rd(8'h0A, 8'h00);
    $display("reset test done");
    t_ram();
    t_rx();
    t_loss();
    results();
  end
  // whole run is about sixty-three cycles, so this span is generous
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule // tb
bind lpr_control_regs lpr_control_regs_sva u_sva (.clk(clk), .reset(reset),
  .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
  .regRead(regRead), .regReadData(regReadData), .rxCtrl(rxCtrl));
